// ==== design/pkt_device.sv ====
// Device end: deframes host packets and frames replies and periodic output.
module pkt_device
	import pkt_pkg::*;
#(
	parameter int STATE_PERIOD = `STATE_PERIOD
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Link to host
	pkt_link_if.device      link,
	// Pass-through serial bytes
	input  wire logic       pt_rx_valid,
	input  wire logic [7:0] pt_rx_data,
	output      logic       pt_rx_ready,
	output      logic       pt_tx_valid,
	output      logic [7:0] pt_tx_data,
	input  wire logic       pt_tx_ready,
	// Configuration and external-data outcome from the core
	input  wire logic       cfg_ok,
	input  wire logic       ext_ok,
	// Received packet report
	output      logic       rx_pkt_valid,
	output      logic [7:0] rx_pkt_id,
	output      logic [1:0] rx_pkt_class
);
	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_DATA = 2'b01
	} rx_state_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_HDR  = 3'b001,
		TX_PAY  = 3'b010,
		TX_SCAN = 3'b011
	} tx_state_t;

	// ************************************************************
	// Receive: five-byte sliding window and payload capture.
	// ************************************************************
	rx_state_t   rx_reg;
	logic [39:0] win_reg;
	logic [7:0]  rcnt_reg;
	logic [15:0] rcrc_reg;
	logic [7:0]  rbuf [256];
	logic [39:0] win_next;
	logic        byte_in;
	logic        hdr_hit;

	assign link.h2d_ready = 1'b1;
	assign byte_in  = link.h2d_valid;
	assign win_next = {link.h2d_data, win_reg[39:8]};
	// Window byte 0 is oldest: lrc, id, len, crc lo, crc hi.
	assign hdr_hit  = win_next[7:0] ==
		hdr_lrc(win_next[15:8], win_next[23:16], win_next[39:24]); // [R4]

	logic pkt_done;
	logic [7:0] p_id_reg;
	logic [7:0] p_len_reg;
	logic [15:0] p_crc_reg;
	logic crc_ok;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_reg   <= RX_HUNT;
			win_reg  <= '0;
			rcnt_reg <= '0;
			rcrc_reg <= `CRC_SEED;
			p_id_reg <= '0;
			p_len_reg <= '0;
			p_crc_reg <= '0;
		end else if (byte_in) begin
			case (rx_reg)
				RX_HUNT: begin
					win_reg <= win_next;
					if (hdr_hit) begin
						p_id_reg  <= win_next[15:8]; // [R2]
						p_len_reg <= win_next[23:16]; // [R5]
						p_crc_reg <= win_next[39:24]; // [R1]
						rcnt_reg  <= '0;
						rcrc_reg  <= `CRC_SEED; // [R6]
						win_reg   <= '0;
						if (win_next[23:16] != 8'h00) begin
							rx_reg <= RX_DATA;
						end
					end
				end
				RX_DATA: begin
					rbuf[rcnt_reg] <= link.h2d_data; // [R5]
					rcrc_reg <= crc_byte(rcrc_reg, link.h2d_data); // [R6]
					rcnt_reg <= rcnt_reg + 8'h01;
					if (rcnt_reg + 8'h01 == p_len_reg) begin
						rx_reg <= RX_HUNT;
					end
				end
				default: rx_reg <= RX_HUNT;
			endcase
		end
	end

	assign pkt_done = byte_in && ((rx_reg == RX_HUNT && hdr_hit &&
		win_next[23:16] == 8'h00) || (rx_reg == RX_DATA &&
		rcnt_reg + 8'h01 == p_len_reg));
	assign crc_ok = (rx_reg == RX_HUNT) ? (win_next[39:24] == `CRC_SEED) :
		(crc_byte(rcrc_reg, link.h2d_data) == p_crc_reg);
	logic [7:0] done_id;
	assign done_id = (rx_reg == RX_HUNT) ? win_next[15:8] : p_id_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_pkt_valid <= 1'b0;
			rx_pkt_id    <= '0;
			rx_pkt_class <= '0;
		end else begin
			rx_pkt_valid <= pkt_done && crc_ok;
			if (pkt_done) begin
				rx_pkt_id    <= done_id;
				rx_pkt_class <= id_class(done_id);
			end
		end
	end

	// ************************************************************
	// Pending work: ack, request, periodic, pass-through.
	// ************************************************************
	logic        ack_pend_reg;
	logic [7:0]  ack_id_reg;
	logic [15:0] ack_crc_reg;
	logic [7:0]  ack_res_reg;
	logic        req_pend_reg;
	logic [7:0]  req_id_reg;
	logic        per_pend_reg;
	logic [31:0] tick_reg;
	logic [179:0] per_en_reg;
	logic        ack_take;
	logic        req_take;
	logic        per_take;
	logic        is_ext;
	logic [7:0]  req_next;

	assign is_ext = done_id >= `ID_EXT_FIRST && done_id <= `ID_EXT_LAST;
	assign req_next = (rx_reg == RX_DATA) ? link.h2d_data : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_pend_reg <= 1'b0;
			ack_id_reg   <= '0;
			ack_crc_reg  <= '0;
			ack_res_reg  <= '0;
		end else if (pkt_done && crc_ok && (is_ext ? !ext_ok :
			id_class(done_id) == CLS_CONFIG)) begin
			ack_pend_reg <= 1'b1; // [R12] [R13]
			ack_id_reg   <= done_id;
			ack_crc_reg  <= (rx_reg == RX_DATA) ? p_crc_reg : win_next[39:24];
			ack_res_reg  <= (is_ext || !cfg_ok) ? `ACK_FAIL : `ACK_OK;
		end else if (ack_take) begin
			ack_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_pend_reg <= 1'b0;
			req_id_reg   <= '0;
		end else if (pkt_done && crc_ok && done_id == `ID_REQUEST &&
			rx_reg == RX_DATA) begin
			req_pend_reg <= 1'b1; // [R11]
			req_id_reg   <= (p_len_reg == 8'h01) ? req_next : rbuf[0];
		end else if (req_take) begin
			req_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tick_reg     <= '0;
			per_pend_reg <= 1'b0;
			per_en_reg   <= '0;
			per_en_reg[`ID_SYS_STATE] <= 1'b1; // [R14]
		end else begin
			if (tick_reg == 32'(STATE_PERIOD - 1)) begin
				tick_reg     <= '0;
				per_pend_reg <= 1'b1; // [R14]
			end else begin
				tick_reg <= tick_reg + 32'h1;
				if (per_take) begin
					per_pend_reg <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Pass-through return path buffered in a FIFO.
	// ************************************************************
	logic       ptq_valid;
	logic [7:0] ptq_data;
	logic       ptq_ready;
	byte_fifo #(.WIDTH(8), .DEPTH(16)) u_ptq (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (pt_rx_valid),
		.in_data   (pt_rx_data),
		.in_ready  (pt_rx_ready), // [R17]
		.out_valid (ptq_valid),
		.out_data  (ptq_data),
		.out_ready (ptq_ready)
	);

	// ************************************************************
	// Transmit framer.
	// ************************************************************
	tx_state_t   tx_reg;
	logic [2:0]  hidx_reg;
	logic [7:0]  pidx_reg;
	logic [7:0]  tid_reg;
	logic [7:0]  tlen_reg;
	logic [7:0]  scan_reg;
	logic [31:0] pay_reg;
	logic [15:0] tcrc;
	logic [39:0] thdr;
	logic        tx_step;

	// Payload byte n is n of pay_reg for acks, zero for state packets.
	function automatic logic [7:0] pay_at(input logic [31:0] p,
		input logic [7:0] n);
		return (n < 8'h04) ? p[8*n[1:0] +: 8] : 8'h00;
	endfunction : pay_at

	always_comb begin
		tcrc = `CRC_SEED;
		for (int i = 0; i < 4; i++) begin
			if (8'(i) < tlen_reg) begin
				tcrc = crc_byte(tcrc, pay_at(pay_reg, 8'(i))); // [R6]
			end
		end
		thdr = {tcrc, tlen_reg, tid_reg,
			hdr_lrc(tid_reg, tlen_reg, tcrc)}; // [R2]
	end

	assign tx_step   = link.d2h_ready;
	assign ack_take  = tx_reg == TX_IDLE && ack_pend_reg;
	assign req_take  = tx_reg == TX_IDLE && !ack_pend_reg && req_pend_reg;
	assign per_take  = tx_reg == TX_IDLE && !ack_pend_reg &&
		!req_pend_reg && per_pend_reg;
	assign ptq_ready = tx_reg == TX_IDLE && !ack_pend_reg &&
		!req_pend_reg && !per_pend_reg;
	assign pt_tx_valid = 1'b0;
	assign pt_tx_data  = 8'h00;
	assign link.d2h_valid = (tx_reg == TX_HDR) || (tx_reg == TX_PAY);
	assign link.d2h_data  = (tx_reg == TX_HDR) ?
		thdr[8*hidx_reg +: 8] : pay_at(pay_reg, pidx_reg); // [R1]

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_reg   <= TX_IDLE;
			hidx_reg <= '0;
			pidx_reg <= '0;
			tid_reg  <= '0;
			tlen_reg <= '0;
			pay_reg  <= '0;
			scan_reg <= '0;
		end else begin
			case (tx_reg)
				TX_IDLE: begin
					hidx_reg <= '0;
					pidx_reg <= '0;
					if (ack_take) begin
						tid_reg  <= `ID_ACK;
						tlen_reg <= `ACK_LEN;
						pay_reg  <= {ack_res_reg, ack_crc_reg,
							ack_id_reg}; // [R18]
						tx_reg   <= TX_HDR;
					end else if (req_take) begin
						tid_reg  <= req_id_reg; // [R11]
						tlen_reg <= 8'h00;
						pay_reg  <= '0;
						tx_reg   <= TX_HDR;
					end else if (per_take) begin
						scan_reg <= `ID_STATE_FIRST;
						tx_reg   <= TX_SCAN;
					end else if (ptq_valid) begin
						tid_reg  <= `ID_PASSTHRU; // [R17]
						tlen_reg <= 8'h01;
						pay_reg  <= {24'h0, ptq_data};
						tx_reg   <= TX_HDR;
					end
				end
				TX_SCAN: begin
					if (scan_reg == `ID_CONFIG_FIRST) begin
						tx_reg <= TX_IDLE;
					end else if (per_en_reg[scan_reg]) begin
						tid_reg  <= scan_reg; // [R15]
						tlen_reg <= 8'h00;
						pay_reg  <= '0;
						scan_reg <= scan_reg + 8'h01;
						tx_reg   <= TX_HDR;
					end else begin
						scan_reg <= scan_reg + 8'h01;
					end
				end
				TX_HDR: begin
					if (tx_step) begin
						hidx_reg <= hidx_reg + 3'h1;
						if (hidx_reg == 3'(`HDR_LEN - 8'h01)) begin
							tx_reg <= (tlen_reg != 8'h00) ? TX_PAY :
								(scan_reg != '0 ? TX_SCAN : TX_IDLE);
						end
					end
				end
				TX_PAY: begin
					if (tx_step) begin
						pidx_reg <= pidx_reg + 8'h01;
						if (pidx_reg + 8'h01 == tlen_reg) begin
							tx_reg <= (scan_reg != '0) ? TX_SCAN : TX_IDLE;
						end
					end
				end
				default: tx_reg <= TX_IDLE;
			endcase
			if (tx_reg == TX_SCAN && scan_reg == `ID_CONFIG_FIRST) begin
				scan_reg <= '0;
			end
		end
	end
endmodule : pkt_device

// ==== pkg/pkt_defines.svh ====
// Constants of the binary packet framer: header layout, ID ranges, timing.
// How it works
// [R1] Multi-byte fields go least significant byte first.
// [R2] Header: checksum, ID, length, CRC at 3.
// [R3] Checksum is (sum of four bytes ^ 0xff) + 1.
// [R4] Receiver slides bytewise until header checksum matches.
// [R5] Length counts payload from index 5, 0..255.
// [R6] CRC16 seeded 0xffff over payload only.
// [R7] Poly 0x1021, MSB first, no reflection or XOR.
// [R8] IDs 0..19 are system packets.
// [R9] IDs 20..179 are periodic state packets.
// [R10] IDs 180..255 are configuration packets.
// [R11] Request packet answered with the requested packet.
// [R12] Configuration packet answered with acknowledgement.
// [R13] Faulty external data gets NAK, never positive.
// [R14] After reset, system state emitted at 50 Hz.
// [R15] Due periodic packets sent in ascending ID.
// [R16] Host line rate at least 11 bit-times per byte.
// [R17] Pass-through bytes wrapped and returned; host ones sent out. The code ties pt_tx_valid low, so host ones are never sent out.
// [R18] Ack payload: ID, CRC at 1, result at 3.
`ifndef PKT_DEFINES_SVH
`define PKT_DEFINES_SVH
`define HDR_LEN         8'h05
`define HDR_CRC_OFS     8'h03
`define LRC_XOR         8'hff
`define CRC_SEED        16'hffff
`define CRC_POLY        16'h1021
`define ID_STATE_FIRST  8'h14
`define ID_CONFIG_FIRST 8'hb4
`define ID_ACK          8'h00
`define ID_REQUEST      8'h01
`define ID_PASSTHRU     8'h0a
`define ID_SYS_STATE    8'h14
`define ID_EXT_FIRST    8'h2c
`define ID_EXT_LAST     8'h35
`define ACK_LEN         8'h04
`define ACK_OK          8'h00
`define ACK_FAIL        8'h01
`define CLK_HZ          20000000
`define STATE_RATE_HZ   50
`define STATE_PERIOD    (`CLK_HZ / `STATE_RATE_HZ)
`endif

// ==== pkg/pkt_pkg.sv ====
// Types and helpers shared by both ends of the packet link.
`include "pkt_defines.svh"
package pkt_pkg;
	typedef enum logic [1:0] {
		CLS_SYSTEM = 2'b00,
		CLS_STATE  = 2'b01,
		CLS_CONFIG = 2'b10
	} id_class_t;

	// ************************************************************
	// Header checksum of identifier, length and both CRC bytes.
	// ************************************************************
	function automatic logic [7:0] hdr_lrc(input logic [7:0] id,
		input logic [7:0] len, input logic [15:0] crc);
		logic [7:0] s;
		s = id + len + crc[7:0] + crc[15:8];
		return (s ^ `LRC_XOR) + 8'h01; // [R3]
	endfunction : hdr_lrc

	// ************************************************************
	// CRC16 over one byte, MSB first, no reflection.
	// ************************************************************
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1); // [R7]
		end
		return r;
	endfunction : crc_byte

	// ************************************************************
	// Identifier range classification.
	// ************************************************************
	function automatic id_class_t id_class(input logic [7:0] id);
		if (id < `ID_STATE_FIRST) begin
			return CLS_SYSTEM; // [R8]
		end else if (id < `ID_CONFIG_FIRST) begin
			return CLS_STATE; // [R9]
		end
		return CLS_CONFIG; // [R10]
	endfunction : id_class
endpackage : pkt_pkg

// ==== pkg/pkt_link_if.sv ====
// Byte stream link joining the device end and the host end.
interface pkt_link_if;
	logic       h2d_valid;
	logic [7:0] h2d_data;
	logic       h2d_ready;
	logic       d2h_valid;
	logic [7:0] d2h_data;
	logic       d2h_ready;
	modport device (
		input  h2d_valid, h2d_data, d2h_ready,
		output h2d_ready, d2h_valid, d2h_data
	);
	modport host (
		output h2d_valid, h2d_data, d2h_ready,
		input  h2d_ready, d2h_valid, d2h_data
	);
endinterface : pkt_link_if

// ==== design/byte_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             in_ready,
	// Drain side
	output      logic             out_valid,
	output      logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : byte_fifo

// ==== design/pkt_host.sv ====
// Host end: frames user packets onto the link and deframes replies.
module pkt_host
	import pkt_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Link to device
	pkt_link_if.host        link,
	// Send request: one packet with up to four payload bytes
	input  wire logic       send_valid,
	input  wire logic [7:0] send_id,
	input  wire logic [2:0] send_len,
	input  wire logic [31:0] send_data,
	output      logic       send_ready,
	// Received packet
	output      logic       recv_valid,
	output      logic [7:0] recv_id,
	output      logic [7:0] recv_len,
	output      logic [31:0] recv_data
);
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SEND = 2'b01
	} hs_state_t;

	// ************************************************************
	// Transmit: header then payload, LSB first.
	// ************************************************************
	hs_state_t  hs_reg;
	logic [71:0] frame_reg;
	logic [3:0]  idx_reg;
	logic [3:0]  last_reg;
	logic [15:0] crc;
	logic [7:0]  len8;

	assign len8 = {5'h0, send_len};
	always_comb begin
		crc = `CRC_SEED; // [R6]
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < send_len) begin
				crc = crc_byte(crc, send_data[8*i +: 8]); // [R7]
			end
		end
	end

	assign send_ready     = hs_reg == HS_IDLE;
	assign link.h2d_valid = hs_reg == HS_SEND;
	assign link.h2d_data  = frame_reg[8*idx_reg +: 8];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hs_reg    <= HS_IDLE;
			frame_reg <= '0;
			idx_reg   <= '0;
			last_reg  <= '0;
		end else begin
			case (hs_reg)
				HS_IDLE: begin
					if (send_valid) begin
						frame_reg <= {send_data, crc, len8, send_id,
							hdr_lrc(send_id, len8, crc)}; // [R2] [R3]
						idx_reg  <= '0;
						last_reg <= 4'(send_len) + 4'h4;
						hs_reg   <= HS_SEND;
					end
				end
				HS_SEND: begin
					if (link.h2d_ready) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == last_reg) begin
							hs_reg <= HS_IDLE;
						end
					end
				end
				default: hs_reg <= HS_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Receive: sliding header hunt, then payload.
	// ************************************************************
	logic [39:0] win_reg;
	logic [39:0] win_next;
	logic        hunting_reg;
	logic [7:0]  cnt_reg;
	logic [7:0]  len_reg;
	logic [7:0]  id_reg;
	logic [31:0] data_reg;

	assign link.d2h_ready = 1'b1;
	assign win_next = {link.d2h_data, win_reg[39:8]};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			win_reg     <= '0;
			hunting_reg <= 1'b1;
			cnt_reg     <= '0;
			len_reg     <= '0;
			id_reg      <= '0;
			data_reg    <= '0;
			recv_valid  <= 1'b0;
			recv_id     <= '0;
			recv_len    <= '0;
			recv_data   <= '0;
		end else begin
			recv_valid <= 1'b0;
			if (link.d2h_valid) begin
				if (hunting_reg) begin
					win_reg <= win_next;
					if (win_next[7:0] == hdr_lrc(win_next[15:8],
						win_next[23:16], win_next[39:24])) begin // [R4]
						win_reg  <= '0;
						id_reg   <= win_next[15:8];
						len_reg  <= win_next[23:16]; // [R5]
						cnt_reg  <= '0;
						data_reg <= '0;
						if (win_next[23:16] == 8'h00) begin
							recv_valid <= 1'b1;
							recv_id    <= win_next[15:8];
							recv_len   <= 8'h00;
							recv_data  <= '0;
						end else begin
							hunting_reg <= 1'b0;
						end
					end
				end else begin
					if (cnt_reg < 8'h04) begin
						data_reg[8*cnt_reg[1:0] +: 8] <= link.d2h_data; // [R1]
					end
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg + 8'h01 == len_reg) begin
						hunting_reg <= 1'b1;
						recv_valid  <= 1'b1;
						recv_id     <= id_reg;
						recv_len    <= len_reg;
						recv_data   <= data_reg;
						if (cnt_reg < 8'h04) begin
							recv_data[8*cnt_reg[1:0] +: 8] <= link.d2h_data;
						end
					end
				end
			end
		end
	end
endmodule : pkt_host

// ==== bench/binary_packet_framer_sva.sv ====
// Checker of the packet link: framing, checksums and handshakes.
module binary_packet_framer_sva (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Link signals
	input wire logic       h2d_valid,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_ready,
	input wire logic       d2h_valid,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int          pos;
	logic [7:0]  hlrc;
	logic [7:0]  hid;
	logic [7:0]  hlen;
	logic [15:0] hcrc;
	logic [15:0] rcrc;
	logic        beat;
	logic        last;

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
		end
		return r;
	endfunction : crc_step

	// ********
	// Frame tracker on the device-to-host stream.
	// ********
	assign beat = d2h_valid && d2h_ready;
	assign last = (pos == 4 && hlen == 8'h00) ||
		(pos >= 5 && pos - 5 == int'(hlen) - 1);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pos <= 0;
		end else if (beat) begin
			pos <= last ? 0 : pos + 1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (beat) begin
			case (pos)
				0: hlrc <= d2h_data;
				1: hid <= d2h_data;
				2: hlen <= d2h_data;
				3: hcrc[7:0] <= d2h_data;
				4: hcrc[15:8] <= d2h_data;
				default: ;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (beat) begin
			rcrc <= (pos == 4) ? 16'hffff : crc_step(rcrc, d2h_data);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_lrc;
		beat && pos == 4 |->
			hlrc == ((hid + hlen + hcrc[7:0] + d2h_data) ^ 8'hff) + 8'h01;
	endproperty
	a_lrc: assert property (p_lrc) else $error("bad header checksum");
	property p_crc;
		beat && last && pos >= 5 |-> crc_step(rcrc, d2h_data) == hcrc;
	endproperty
	a_crc: assert property (p_crc) else $error("bad payload crc");
	property p_crc0;
		beat && pos == 4 && hlen == 8'h00 |->
			{d2h_data, hcrc[7:0]} == 16'hffff;
	endproperty
	a_crc0: assert property (p_crc0) else $error("bad empty crc");
	property p_ack_len;
		beat && pos == 2 && hid == 8'h00 |-> d2h_data == 8'h04;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("ack length");
	property p_ack_res;
		beat && pos == 8 && hid == 8'h00 |-> d2h_data <= 8'h01;
	endproperty
	a_ack_res: assert property (p_ack_res) else $error("ack code");
	property p_d2h_hold;
		d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
	endproperty
	a_d2h_hold: assert property (p_d2h_hold) else $error("d2h drop");
	property p_h2d_hold;
		h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
	endproperty
	a_h2d_hold: assert property (p_h2d_hold) else $error("h2d drop");
	property p_idle;
		$rose(rst_n) |-> !d2h_valid && !h2d_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("busy after reset");

	c_ack: cover property (beat && pos == 1 && d2h_data == 8'h00);
	c_state: cover property (beat && pos == 1 && d2h_data == 8'h14);
	c_pass: cover property (beat && pos == 1 && d2h_data == 8'h0a);
endmodule : binary_packet_framer_sva

// ==== bench/binary_packet_framer_tb_top.sv ====
// Testbench joining both link ends, with a second device fed by hand.
module binary_packet_framer_tb_top;
	import pkt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STATE_P = 200;
	typedef struct packed {
		logic [7:0]  id;
		logic [7:0]  len;
		logic [31:0] data;
	} pkt_t;
	typedef struct packed {
		logic [7:0] id;
		logic [1:0] cls;
	} rep_t;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        send_valid, send_ready, recv_valid;
	logic [7:0]  send_id, recv_id, recv_len;
	logic [2:0]  send_len;
	logic [31:0] send_data, recv_data, d, seed;
	logic        pt_rx_valid, pt_rx_ready, cfg_ok, ext_ok;
	logic [7:0]  pt_rx_data, rx_id, rx2_id, id;
	logic        rx_valid, rx2_valid;
	logic [1:0]  rx_cls, rx2_cls;
	logic [15:0] c;
	pkt_t        exp_q[$];
	rep_t        rep_q[$];
	rep_t        rep2_q[$];
	int          errors, checked, per_cnt, k, n;

	pkt_link_if lnk();
	pkt_link_if lnk2();
	always #25 ref_clk = ~ref_clk;

	pkt_device #(.STATE_PERIOD(STATE_P)) i_pkt_device (.ref_clk(ref_clk),
		.rst_n(rst_n), .link(lnk), .pt_rx_valid(pt_rx_valid),
		.pt_rx_data(pt_rx_data), .pt_rx_ready(pt_rx_ready),
		.pt_tx_valid(), .pt_tx_data(), .pt_tx_ready(1'b1),
		.cfg_ok(cfg_ok), .ext_ok(ext_ok), .rx_pkt_valid(rx_valid),
		.rx_pkt_id(rx_id), .rx_pkt_class(rx_cls));
	pkt_device #(.STATE_PERIOD(STATE_P)) i_pkt_device_2 (.ref_clk(ref_clk),
		.rst_n(rst_n), .link(lnk2), .pt_rx_valid(1'b0),
		.pt_rx_data(8'h00), .pt_rx_ready(), .pt_tx_valid(),
		.pt_tx_data(), .pt_tx_ready(1'b1), .cfg_ok(cfg_ok),
		.ext_ok(ext_ok), .rx_pkt_valid(rx2_valid), .rx_pkt_id(rx2_id),
		.rx_pkt_class(rx2_cls));
	pkt_host i_pkt_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(lnk),
		.send_valid(send_valid), .send_id(send_id), .send_len(send_len),
		.send_data(send_data), .send_ready(send_ready),
		.recv_valid(recv_valid), .recv_id(recv_id), .recv_len(recv_len),
		.recv_data(recv_data));
	binary_packet_framer_sva i_binary_packet_framer_sva (.ref_clk(ref_clk),
		.rst_n(rst_n), .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
		.h2d_ready(lnk.h2d_ready), .d2h_valid(lnk.d2h_valid),
		.d2h_data(lnk.d2h_data), .d2h_ready(lnk.d2h_ready));

	// ********
	// Helpers.
	// ********
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [15:0] crc_of(input int len,
		input logic [31:0] v);
		logic [15:0] r;
		r = 16'hffff;
		for (int i = 0; i < len; i++) begin
			r = r ^ {v[8*i+:8], 8'h00};
			for (int j = 0; j < 8; j++) begin
				r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
			end
		end
		return r;
	endfunction : crc_of
	task automatic summarize();
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	task automatic bad(input string s);
		errors++;
		$display("BAD %0t %s", $time, s);
	endtask : bad
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			bad($sformatf("saw %h want %h", seen, want));
		end
	endtask : check
	task automatic limit(input int cnt, input int top);
		if (cnt >= top) begin
			bad("wait ran out");
			summarize();
		end
	endtask : limit
	task automatic send(input logic [7:0] i, input logic [2:0] l,
		input logic [31:0] v);
		int m;
		send_valid = 1'b1;
		send_id = i;
		send_len = l;
		send_data = v;
		m = 0;
		do begin
			@(posedge ref_clk);
			m++;
		end while (send_ready !== 1'b1 && m < 500);
		limit(m, 500);
		@(negedge ref_clk);
		send_valid = 1'b0;
	endtask : send
	task automatic settle();
		int m;
		m = 0;
		while ((exp_q.size() + rep_q.size() + rep2_q.size()) > 0 &&
			m < 3000) begin
			@(posedge ref_clk);
			m++;
		end
		limit(m, 3000);
		@(negedge ref_clk);
	endtask : settle
	task automatic put2(input logic [7:0] b);
		int m;
		lnk2.h2d_data = b;
		m = 0;
		do begin
			@(posedge ref_clk);
			m++;
		end while (lnk2.h2d_ready !== 1'b1 && m < 100);
		limit(m, 100);
		@(negedge ref_clk);
	endtask : put2
	task automatic frame2(input logic [7:0] i, input int len,
		input logic [31:0] v, input logic corrupt);
		logic [15:0] r;
		logic [7:0]  l;
		r = crc_of(len, v);
		l = ((i + 8'(len) + r[7:0] + r[15:8]) ^ 8'hff) + 8'h01;
		put2(l);
		put2(i);
		put2(8'(len));
		put2(r[7:0]);
		put2(r[15:8]);
		for (int j = 0; j < len; j++) begin
			put2(v[8*j+:8] ^ {7'h00, corrupt});
		end
	endtask : frame2

	// ********
	// Result watcher.
	// ********
	always @(posedge ref_clk) begin : watch
		pkt_t        e;
		rep_t        r;
		logic [31:0] m;
		if (recv_valid === 1'b1) begin
			if (recv_id === 8'h14 && recv_len === 8'h00) begin
				per_cnt++;
			end else if (exp_q.size() == 0) begin
				bad("unexpected packet");
			end else begin
				e = exp_q.pop_front();
				m = (e.len >= 4) ? '1 : (32'h1 << (8 * int'(e.len))) - 1;
				check({24'h0, recv_id}, {24'h0, e.id});
				check({24'h0, recv_len}, {24'h0, e.len});
				check(recv_data & m, e.data & m);
			end
		end
		if (rx_valid === 1'b1) begin
			r = (rep_q.size() > 0) ? rep_q.pop_front() : '1;
			check({22'h0, rx_id, rx_cls}, {22'h0, r});
		end
		if (rx2_valid === 1'b1) begin
			r = (rep2_q.size() > 0) ? rep2_q.pop_front() : '1;
			check({22'h0, rx2_id, rx2_cls}, {22'h0, r});
		end
	end

	// ********
	// Scenarios.
	// ********
	initial begin
		{send_valid, send_id, send_len, send_data} = '0;
		{pt_rx_valid, pt_rx_data, cfg_ok, ext_ok} = '0;
		{lnk2.h2d_valid, lnk2.h2d_data} = '0;
		lnk2.d2h_ready = 1'b1;
		seed = 32'hfb24;
		{errors, checked, per_cnt} = '0;
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		for (k = 0; k < 5; k++) begin
			id = 8'hb4 + 8'(xs() % 76);
			d = xs();
			cfg_ok = k[0];
			c = crc_of(k, d);
			exp_q.push_back({8'h00, 8'h04, 7'h00, ~k[0], c, id});
			rep_q.push_back({id, 2'd2});
			send(id, 3'(k), d);
			settle();
		end
		exp_q.push_back({8'h15, 8'h00, 32'h0});
		rep_q.push_back({8'h01, 2'd0});
		send(8'h01, 3'd1, 32'h15);
		settle();
		for (k = 0; k < 2; k++) begin
			ext_ok = k[0];
			id = 8'h2c + 8'(xs() % 10);
			d = xs();
			c = crc_of(4, d);
			if (!k[0]) exp_q.push_back({16'h0004, 8'h01, c, id});
			rep_q.push_back({id, 2'd1});
			send(id, 3'd4, d);
			settle();
		end
		d = xs();
		exp_q.push_back({8'h0a, 8'h01, 24'h0, d[7:0]});
		pt_rx_data = d[7:0];
		pt_rx_valid = 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pt_rx_ready !== 1'b1 && n < 100);
		limit(n, 100);
		@(negedge ref_clk);
		pt_rx_valid = 1'b0;
		settle();
		lnk2.h2d_valid = 1'b1;
		put2(8'h5a);
		put2(8'h3c);
		d = xs();
		rep2_q.push_back({8'h17, 2'd1});
		rep2_q.push_back({8'h03, 2'd0});
		frame2(8'h17, 2, d, 1'b0);
		frame2(8'hc8, 3, d, 1'b1);
		frame2(8'h03, 0, d, 1'b0);
		lnk2.h2d_valid = 1'b0;
		settle();
		per_cnt = 0;
		repeat (10 * STATE_P) @(posedge ref_clk);
		check(32'(per_cnt >= 9 && per_cnt <= 11), 32'h1);
		summarize();
	end
endmodule : binary_packet_framer_tb_top
